// ---- hdl/ocp_top.sv ----
// optional configuration pin control with wishbone register access
//
// Decided for this implementation: the register addresses and the Wishbone register port.
module ocp_top #(
	parameter int IO_W = 8
) (
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	input  wire logic            ce_i,
	input  wire logic            config_restart_n_i,
	input  wire logic            user_startup_clock_i,
	input  wire logic            termination_cal_complete_i,
	input  wire logic            global_output_enable_i,
	input  wire logic            global_register_clear_n_i,
	input  wire logic [IO_W-1:0] user_io_oe_i,
	output logic [IO_W-1:0]      user_io_oe_o,
	output logic                 user_reg_clear_o,
	output logic                 init_done_o,
	output logic                 init_done_oe_o,
	output logic                 opt_pin_pullup_o,
	output logic                 user_mode_o,
	input  wire logic [3:0]      wb_adr_i,
	input  wire logic [31:0]     wb_dat_i,
	output logic [31:0]          wb_dat_o,
	input  wire logic            wb_we_i,
	input  wire logic [3:0]      wb_sel_i,
	input  wire logic            wb_cyc_i,
	input  wire logic            wb_stb_i,
	output logic                 wb_ack_o
);
	logic [ocp_pkg::OCP_CTL_W-1:0] ctl_r, ctl_nxt;
	logic [15:0]                   initc_r, initc_nxt;
	logic [15:0]                   cnt_r, cnt_nxt;
	ocp_pkg::ocp_state_t           st_r, st_nxt;
	logic                          ack_r, ack_nxt;
	logic [31:0]                   dat_r, dat_nxt;
	logic [IO_W-1:0]               oe_r, oe_nxt;
	logic                          clr_r, clr_nxt;
	logic                          odrv_r, odrv_nxt;
	logic                          pu_r, pu_nxt;
	logic                          um_r, um_nxt;
	logic                          usr_rise;
	logic                          tick;
	logic                          cal_ok;
	logic                          wr;

	function automatic logic sel_hit(input logic [3:0] a, input logic [3:0] t);
		return a == t;
	endfunction

	ocp_edge u_edge (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.ce_i   (ce_i),
		.d_i    (user_startup_clock_i),
		.rise_o (usr_rise)
	);

	// start-up clock source
	assign tick = ctl_r[ocp_pkg::OCP_CTL_USER_STARTUP_CLOCK_EN] ? usr_rise : 1'b1;
	assign cal_ok = ~ctl_r[ocp_pkg::OCP_CTL_CALGATE] | termination_cal_complete_i;
	assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r & wb_sel_i[0];

	// register bus
	always_comb begin
		ctl_nxt   = ctl_r;
		initc_nxt = initc_r;
		ack_nxt   = wb_cyc_i & wb_stb_i & ~ack_r;
		dat_nxt   = dat_r;
		if (wr && sel_hit(wb_adr_i, ocp_pkg::OCP_ADR_CTRL)) begin
			ctl_nxt = wb_dat_i[ocp_pkg::OCP_CTL_W-1:0];
		end
		if (wr && sel_hit(wb_adr_i, ocp_pkg::OCP_ADR_INITC)) begin
			initc_nxt = wb_dat_i[15:0];
		end
		if (ack_nxt && !wb_we_i) begin
			if (sel_hit(wb_adr_i, ocp_pkg::OCP_ADR_CTRL)) begin
				dat_nxt = {{(32-ocp_pkg::OCP_CTL_W){1'b0}}, ctl_r};
			end else if (sel_hit(wb_adr_i, ocp_pkg::OCP_ADR_STATUS)) begin
				dat_nxt = {24'h000000, st_r, odrv_r, um_r, clr_r, termination_cal_complete_i};
			end else if (sel_hit(wb_adr_i, ocp_pkg::OCP_ADR_INITC)) begin
				dat_nxt = {16'h0000, initc_r};
			end else begin
				dat_nxt = 32'h00000000;
			end
		end
		if (ctl_r[ocp_pkg::OCP_CTL_FRAME] && st_r != ocp_pkg::OCP_ST_RESET) begin
			ctl_nxt[ocp_pkg::OCP_CTL_FRAME] = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl_r   <= ocp_pkg::OCP_CTL_RST;
			initc_r <= ocp_pkg::OCP_INIT_CYC_DEF;
			ack_r   <= 1'b0;
			dat_r   <= 32'h00000000;
		end else if (ce_i) begin
			ctl_r   <= ctl_nxt;
			initc_r <= initc_nxt;
			ack_r   <= ack_nxt;
			dat_r   <= dat_nxt;
		end
	end

	// configuration sequence
	always_comb begin
		st_nxt  = st_r;
		cnt_nxt = cnt_r;
		case (st_r)
			ocp_pkg::OCP_ST_RESET: begin
				if (ctl_r[ocp_pkg::OCP_CTL_FRAME]) begin
					st_nxt = ocp_pkg::OCP_ST_FRAME;
				end
			end
			ocp_pkg::OCP_ST_FRAME: begin
				st_nxt  = ocp_pkg::OCP_ST_INIT;
				cnt_nxt = initc_r;
			end
			ocp_pkg::OCP_ST_INIT: begin
				if (tick && cnt_r != 16'h0000) begin
					cnt_nxt = cnt_r - 16'h0001;
				end
				if (cnt_r == 16'h0000 && cal_ok) begin
					st_nxt = ocp_pkg::OCP_ST_USER;
				end
			end
			ocp_pkg::OCP_ST_USER: begin
				st_nxt = ocp_pkg::OCP_ST_USER;
			end
			default: begin
				st_nxt = ocp_pkg::OCP_ST_RESET;
			end
		endcase
		if (!config_restart_n_i) begin
			st_nxt  = ocp_pkg::OCP_ST_RESET;
			cnt_nxt = 16'h0000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r  <= ocp_pkg::OCP_ST_RESET;
			cnt_r <= 16'h0000;
		end else if (ce_i) begin
			st_r  <= st_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// pin outputs
	always_comb begin
		um_nxt   = st_nxt == ocp_pkg::OCP_ST_USER;
		odrv_nxt = ctl_r[ocp_pkg::OCP_CTL_DONE_EN] &&
			(st_nxt == ocp_pkg::OCP_ST_FRAME || st_nxt == ocp_pkg::OCP_ST_INIT);
		pu_nxt   = ~um_nxt;
		oe_nxt   = um_nxt ? user_io_oe_i : {IO_W{1'b0}};
		if (ctl_r[ocp_pkg::OCP_CTL_OE_EN] && !global_output_enable_i) begin
			oe_nxt = {IO_W{1'b0}};
		end
		clr_nxt  = ctl_r[ocp_pkg::OCP_CTL_CLR_EN] & ~global_register_clear_n_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			um_r   <= 1'b0;
			odrv_r <= 1'b0;
			pu_r   <= 1'b1;
			oe_r   <= {IO_W{1'b0}};
			clr_r  <= 1'b0;
		end else if (ce_i) begin
			um_r   <= um_nxt;
			odrv_r <= odrv_nxt;
			pu_r   <= pu_nxt;
			oe_r   <= oe_nxt;
			clr_r  <= clr_nxt;
		end
	end

	assign user_io_oe_o     = oe_r;
	assign user_reg_clear_o = clr_r;
	assign init_done_o      = 1'b0;
	assign init_done_oe_o   = odrv_r;
	assign opt_pin_pullup_o = pu_r;
	assign user_mode_o      = um_r;
	assign wb_dat_o         = dat_r;
	assign wb_ack_o         = ack_r;
endmodule

// ---- pkg/ocp_pkg.sv ----
// constants and types for the optional configuration pin control block
package ocp_pkg;
	typedef enum logic [3:0] {
		OCP_ST_RESET = 4'h1,
		OCP_ST_FRAME = 4'h2,
		OCP_ST_INIT  = 4'h4,
		OCP_ST_USER  = 4'h8
	} ocp_state_t;

	// register map, byte addresses
	localparam logic [3:0] OCP_ADR_CTRL   = 4'h0;
	localparam logic [3:0] OCP_ADR_STATUS = 4'h4;
	localparam logic [3:0] OCP_ADR_INITC  = 4'h8;

	// control field positions
	localparam int OCP_CTL_USER_STARTUP_CLOCK_EN = 0;
	localparam int OCP_CTL_DONE_EN   = 1;
	localparam int OCP_CTL_CALGATE   = 2;
	localparam int OCP_CTL_OE_EN     = 3;
	localparam int OCP_CTL_CLR_EN    = 4;
	localparam int OCP_CTL_FRAME     = 5;
	localparam int OCP_CTL_W         = 6;
	localparam logic [OCP_CTL_W-1:0] OCP_CTL_RST = 6'h00;

	// timing
	localparam int OCP_CLK_HZ       = 40_000_000;
	localparam int OCP_RESTART_NS   = 500;
	localparam int OCP_RESTART_CYC  =
		(OCP_RESTART_NS * (OCP_CLK_HZ / 1_000_000) + 999) / 1000;
	localparam logic [15:0] OCP_INIT_CYC_DEF = 16'h0020;
endpackage

// ---- hdl/ocp_edge.sv ----
// rising edge detector for a sampled start-up clock input
module ocp_edge (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	input  wire logic d_i,
	output logic      rise_o
);
	logic d_r;
	logic d_nxt;

	always_comb begin
		d_nxt = ce_i ? d_i : d_r;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			d_r <= 1'b0;
		end else begin
			d_r <= d_nxt;
		end
	end

	assign rise_o = ce_i & d_i & ~d_r;
endmodule

// ---- verif/ocp_top_properties.sv ----
// assertions on the pins of the configuration pin block
module ocp_top_properties #(parameter int IO_W = 8) (
	input wire logic	clk_i,
	input wire logic	rst_i,
	input wire logic	config_restart_n_i,
	input wire logic	global_output_enable_i,
	input wire logic	global_register_clear_n_i,
	input wire logic [IO_W-1:0]	user_io_oe_i,
	input wire logic [IO_W-1:0]	user_io_oe_o,
	input wire logic	user_reg_clear_o,
	input wire logic	init_done_o,
	input wire logic	init_done_oe_o,
	input wire logic	opt_pin_pullup_o,
	input wire logic	user_mode_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_user; user_mode_o && !opt_pin_pullup_o; endsequence
	property p_pull; !user_mode_o && !$past(user_mode_o) |-> opt_pin_pullup_o; endproperty
	a_pull: assert property (p_pull) else $error("pullup");
	property p_rst; !config_restart_n_i |=> !init_done_oe_o && !user_mode_o; endproperty
	a_rst: assert property (p_rst) else $error("restart");
	property p_drv; $rose(init_done_oe_o) |-> !user_mode_o && !init_done_o; endproperty
	a_drv: assert property (p_drv) else $error("drive");
	property p_rel; $fell(init_done_oe_o) && $past(config_restart_n_i) |-> s_user; endproperty
	a_rel: assert property (p_rel) else $error("release");
	property p_um; $rose(user_mode_o) |-> !init_done_oe_o; endproperty
	a_um: assert property (p_um) else $error("user mode");
	property p_oe; user_mode_o && config_restart_n_i && global_output_enable_i
		&& $past(global_output_enable_i) |=> user_io_oe_o == $past(user_io_oe_i); endproperty
	a_oe: assert property (p_oe) else $error("oe");
	property p_clr; global_register_clear_n_i[*2] |=> !user_reg_clear_o; endproperty
	a_clr: assert property (p_clr) else $error("clear");
	property p_stay; user_mode_o && config_restart_n_i && global_register_clear_n_i
		|=> user_mode_o; endproperty
	a_stay: assert property (p_stay) else $error("stay");
endmodule

// ---- verif/ocp_host_model.sv ----
// board host and done line monitor
module ocp_host_model (
	input wire logic	clk_i,
	input wire logic	restart_req_i,
	input wire logic	init_done_i,
	input wire logic	init_done_oe_i,
	output logic	config_restart_n_o,
	output logic [3:0]	done_rises_o = 4'h0
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0]	low_r = 5'h00;
	logic	line_r = 1'b1;
	wire logic	line = init_done_oe_i ? init_done_i : 1'b1;
	assign config_restart_n_o = (low_r == 5'h00);
	always @(posedge clk_i) begin
		if (restart_req_i)
			low_r <= 5'(ocp_pkg::OCP_RESTART_CYC);
		else if (low_r != 5'h00)
			low_r <= low_r - 5'h01;
		line_r <= line;
		if (line && !line_r)
			done_rises_o <= done_rises_o + 4'h1;
	end
endmodule

// ---- verif/ocp_top_test.sv ----
// self-checking bench for the configuration pin block
module ocp_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic	clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, user_startup_clock_i = 1'b0;
	logic	termination_cal_complete_i = 1'b0, global_output_enable_i = 1'b1;
	logic	global_register_clear_n_i = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
	logic	rq = 1'b0, config_restart_n_i, user_reg_clear_o, init_done_o, init_done_oe_o;
	logic	opt_pin_pullup_o, user_mode_o, wb_ack_o;
	logic [3:0]	wb_adr_i = 4'h0, wb_sel_i = 4'hf, rises;
	logic [7:0]	user_io_oe_i = 8'ha5, user_io_oe_o;
	logic [31:0]	wb_dat_i = 32'h0, wb_dat_o, rd;
	int	n_errors = 0, checks_done = 0;
	`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
		$display("wrong value %s exp %h got %h", n, e, g); end end
	always #12.5 clk_i = ~clk_i;
	ocp_top #(.IO_W(8)) uut (.clk_i, .rst_i, .ce_i, .config_restart_n_i, .user_startup_clock_i,
		.termination_cal_complete_i, .global_output_enable_i, .global_register_clear_n_i,
		.user_io_oe_i, .user_io_oe_o, .user_reg_clear_o, .init_done_o, .init_done_oe_o,
		.opt_pin_pullup_o, .user_mode_o, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i,
		.wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o);
	ocp_host_model host (.clk_i, .restart_req_i(rq), .init_done_i(init_done_o),
		.init_done_oe_i(init_done_oe_o), .config_restart_n_o(config_restart_n_i),
		.done_rises_o(rises));
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
		i = 0;
		do begin @(posedge clk_i); i++; end while (wb_ack_o !== 1'b1 && i < 40);
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		if (wb_ack_o !== 1'b1) begin n_errors++; report_and_stop(); end
	endtask
	task automatic wait_user;
		for (int i = 0; i < 300 && user_mode_o !== 1'b1; i++) @(posedge clk_i);
		`CHK("user mode", 1'b1, user_mode_o)
		`CHK("released", 1'b0, init_done_oe_o)
		if (user_mode_o !== 1'b1) report_and_stop();
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		`CHK("pullup", 1'b1, opt_pin_pullup_o)
		`CHK("undriven", 1'b0, init_done_oe_o)
		wb(1'b0, 4'hc, 32'h0);
		`CHK("unmapped", 32'h0, rd)
		wb(1'b1, ocp_pkg::OCP_ADR_INITC, 32'h3);
		wb(1'b1, ocp_pkg::OCP_ADR_CTRL, 32'h06);
		wb(1'b1, ocp_pkg::OCP_ADR_CTRL, 32'h26);
		repeat (2) @(posedge clk_i);
		`CHK("done low", 1'b1, init_done_oe_o)
		repeat (30) @(posedge clk_i);
		`CHK("gated", 1'b0, user_mode_o)
		termination_cal_complete_i <= 1'b1;
		wait_user();
		`CHK("pullup off", 1'b0, opt_pin_pullup_o)
		`CHK("done data", 1'b0, init_done_o)
		wb(1'b0, ocp_pkg::OCP_ADR_STATUS, 32'h0);
		`CHK("status", 32'h00000085, rd)
		wb(1'b1, ocp_pkg::OCP_ADR_CTRL, 32'h18);
		repeat (2) @(posedge clk_i);
		`CHK("io oe", 8'ha5, user_io_oe_o)
		`CHK("rises", 4'h1, rises)
		`CHK("stays", 1'b1, user_mode_o)
		{global_output_enable_i, global_register_clear_n_i} <= 2'b00;
		repeat (3) @(posedge clk_i);
		`CHK("io off", 8'h00, user_io_oe_o)
		`CHK("clear", 1'b1, user_reg_clear_o)
		{global_output_enable_i, global_register_clear_n_i, rq} <= 3'b111;
		@(posedge clk_i);
		rq <= 1'b0;
		repeat (3) @(posedge clk_i);
		`CHK("restart", 1'b0, user_mode_o)
		repeat (25) @(posedge clk_i);
		termination_cal_complete_i <= 1'b0;
		wb(1'b1, ocp_pkg::OCP_ADR_INITC, 32'h3);
		wb(1'b1, ocp_pkg::OCP_ADR_CTRL, 32'h23);
		repeat (40) @(posedge clk_i);
		`CHK("no ticks", 1'b0, user_mode_o)
		ce_i <= 1'b0;
		repeat (4) begin repeat (2) @(posedge clk_i); user_startup_clock_i <= ~user_startup_clock_i; end
		repeat (2) @(posedge clk_i);
		ce_i <= 1'b1;
		@(posedge clk_i);
		`CHK("frozen", 1'b0, user_mode_o)
		repeat (10) begin repeat (2) @(posedge clk_i); user_startup_clock_i <= ~user_startup_clock_i; end
		wait_user();
		report_and_stop();
	end
endmodule
bind ocp_top ocp_top_properties #(.IO_W(IO_W)) u_props (.clk_i, .rst_i, .config_restart_n_i,
	.global_output_enable_i, .global_register_clear_n_i, .user_io_oe_i, .user_io_oe_o,
	.user_reg_clear_o, .init_done_o, .init_done_oe_o, .opt_pin_pullup_o, .user_mode_o);
